// >>> hdl/mbc_regs.svh
// Named constants of the slave configuration and dispatch block.
// Assumes a 125 MHz system clock and 16-bit holding registers.
`ifndef MBC_REGS_SVH
`define MBC_REGS_SVH

// Holding register offsets.
`define MBC_OFS_SLAVE     16'h0000
`define MBC_OFS_BAUD      16'h0001
`define MBC_OFS_PARITY    16'h0002
`define MBC_OFS_BITS      16'h0003
`define MBC_OFS_STOP      16'h0004
`define MBC_OFS_MODE      16'h0005
`define MBC_OFS_WDT       16'h0006
`define MBC_OFS_DELAY     16'h0007
`define MBC_OFS_REBOOT    16'h0008
`define MBC_OFS_FW_REV    16'h0009

// Value that must be written to the reboot register to restart.
`define MBC_REBOOT_KEY    16'h00A5

// Factory defaults.
`define MBC_DEF_SLAVE     16'h0001
`define MBC_DEF_BAUD      16'h0060
`define MBC_DEF_PARITY    16'h0000
`define MBC_DEF_BITS      16'h0008
`define MBC_DEF_STOP      16'h0001
`define MBC_DEF_MODE      16'h0001
`define MBC_DEF_WDT       16'h0000
`define MBC_DEF_DELAY     16'h0000

// Line settings of the firmware-load mode.
`define MBC_LOAD_BAUD     16'h00C0
`define MBC_LOAD_BITS     16'h0008
`define MBC_LOAD_PARITY   16'h0000
`define MBC_LOAD_STOP     16'h0001

// Function codes.
`define MBC_FN_RD_COILS   8'h01
`define MBC_FN_RD_HOLD    8'h03
`define MBC_FN_WR_COIL    8'h05
`define MBC_FN_WR_REG     8'h06
`define MBC_FN_EXC_STAT   8'h07
`define MBC_FN_DIAG       8'h08
`define MBC_FN_WR_COILS   8'h0F
`define MBC_FN_WR_REGS    8'h10
`define MBC_FN_SLAVE_ID   8'h11
`define MBC_FN_MASK_WR    8'h16
`define MBC_FN_RW_REGS    8'h17
`define MBC_FN_EXC_FLAG   8'h80

// Diagnostics sub-functions, exception codes, fixed status byte.
`define MBC_SUB_ECHO      16'h0000
`define MBC_SUB_RESTART   16'h0001
`define MBC_EXC_FUNC      8'h01
`define MBC_EXC_ADDR      8'h02
`define MBC_EXC_STATUS    16'h0000

// Timing: clock period, watchdog tick and LED half period in ns.
`define MBC_CLK_PERIOD_NS 8
`define MBC_WDT_TICK_NS   1000000000
`define MBC_BLINK_HALF_NS 250000000

`endif

// >>> hdl/mbc_pkg.sv
// Types shared by the slave configuration and dispatch block.
// Assumes nothing beyond a SystemVerilog compiler.
package mbc_pkg;

  // Boot to run is the usual path; firmware load branches off boot.
  typedef enum logic [1:0]
  {
    MBC_ST_BOOT   = 2'b00,
    MBC_ST_RUN    = 2'b01,
    MBC_ST_FWLOAD = 2'b10
  } mbc_state_e;

  typedef logic [15:0] mbc_word_t;

endpackage

// >>> hdl/mbc_blink.sv
// Indicator LED blinker used while a firmware image is awaited.
// Assumes a free running clock and a synchronous active high reset.
`timescale 1ns/1ns

module mbc_blink
#(
  parameter int unsigned HALF_CYCLES = 31250000
)
(
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic enable_i,
  output logic      led_o
);

  logic [31:0] count_q;

  always_ff @(posedge clock_i)
  begin
    if (srst_i || !enable_i)
    begin
      count_q <= 32'h0000_0000;
      led_o   <= 1'b0;
    end
    else if (count_q == HALF_CYCLES - 32'h0000_0001)
    begin
      count_q <= 32'h0000_0000;
      led_o   <= !led_o;
    end
    else
    begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

endmodule

// >>> hdl/mbc_dispatch.sv
// Configuration and request dispatch of a serial bus slave.
// Assumes a frame layer that hands over checked, addressed requests
// and a non-volatile store that presents its saved parameters.
//
// Overview of operation
// - Firmware revision register is read-only; writes leave it unchanged.
// - Reset with init jumper loads factory defaults before answering.
// - Defaults: address 1, 9600, no parity, 8 bits, 1 stop, RTU, 0, 0.
// - Parameter writes go to storage; live settings wait for reset, except the watchdog period, which acts at once.
// - Reset without jumper copies stored parameters in and enters run.
// - Button, diagnostics restart and reboot register all reload as reset.
// - Serve codes 01,03,05,06,07,08,15,16,17,22,23.
// - Read exception status replies with status byte 0x00.
// - Load jumper selects 19200 baud, 8 bits, no parity, 1 stop.
// - LED blinks in load mode; only reset without jumper leaves it.
// - Watchdog value zero disables; commands restart it; expiry fail-safe.
// - Unsupported function or register gets an exception reply.
`timescale 1ns/1ns
`include "mbc_regs.svh"

module mbc_dispatch
  import mbc_pkg::*;
#(
  // Arbitrary revision value; software reads it back unchanged.
  parameter logic [15:0] FW_REV       = 16'h0101,
  parameter int unsigned WDT_TICK     = `MBC_WDT_TICK_NS / `MBC_CLK_PERIOD_NS,
  parameter int unsigned BLINK_CYCLES = `MBC_BLINK_HALF_NS / `MBC_CLK_PERIOD_NS
)
(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        jumper_init_i,
  input  wire logic        jumper_load_i,
  input  wire logic [15:0] nvm_slave_i,
  input  wire logic [15:0] nvm_baud_i,
  input  wire logic [15:0] nvm_parity_i,
  input  wire logic [15:0] nvm_bits_i,
  input  wire logic [15:0] nvm_stop_i,
  input  wire logic [15:0] nvm_mode_i,
  input  wire logic [15:0] nvm_wdt_i,
  input  wire logic [15:0] nvm_delay_i,
  input  wire logic        req_valid_i,
  input  wire logic [7:0]  req_func_i,
  input  wire logic [15:0] req_addr_i,
  input  wire logic [15:0] req_data_i,
  output logic             reply_valid_o,
  output logic [7:0]       reply_func_o,
  output logic             reply_exc_o,
  output logic [7:0]       reply_code_o,
  output logic [15:0]      reply_data_o,
  output logic             reply_fwd_o,
  output logic             nvm_we_o,
  output logic [15:0]      nvm_addr_o,
  output logic [15:0]      nvm_wdata_o,
  output logic [15:0]      slave_addr_o,
  output logic [15:0]      baud_code_o,
  output logic [15:0]      parity_o,
  output logic [15:0]      data_bits_o,
  output logic [15:0]      stop_bits_o,
  output logic [15:0]      frame_mode_o,
  output logic [15:0]      link_silence_timer_o,
  output logic [15:0]      reply_delay_o,
  output logic             run_o,
  output logic             fw_load_o,
  output logic             failsafe_o,
  output logic             led_o
);

  mbc_state_e  state_q;
  logic        restart_q;
  logic        take;
  logic        exc_d;
  logic [7:0]  code_d;
  logic [15:0] data_d;
  logic        fwd_d;
  logic        nvm_d;
  logic        restart_d;
  logic [31:0] tick_q;
  logic [15:0] secs_q;
  logic        expired_q;

  function automatic logic is_supported(input logic [7:0] fn);
    unique case (fn)
      `MBC_FN_RD_COILS, `MBC_FN_RD_HOLD, `MBC_FN_WR_COIL, `MBC_FN_WR_REG,
      `MBC_FN_EXC_STAT, `MBC_FN_DIAG, `MBC_FN_WR_COILS, `MBC_FN_WR_REGS,
      `MBC_FN_SLAVE_ID, `MBC_FN_MASK_WR, `MBC_FN_RW_REGS:
        is_supported = 1'b1;
      default:
        is_supported = 1'b0;
    endcase
  endfunction

  function automatic logic is_param(input logic [15:0] a);
    is_param = (a <= `MBC_OFS_DELAY);
  endfunction

  function automatic logic reg_exists(input logic [15:0] a);
    reg_exists = (a <= `MBC_OFS_FW_REV);
  endfunction

  // Requests are only taken in run, never while a restart is pending.
  assign take = req_valid_i && (state_q == MBC_ST_RUN) && !restart_q;
  assign run_o = state_q[0];
  assign fw_load_o = state_q[1];

  // Load mode is left only by a reset taken with the jumper removed.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      state_q <= MBC_ST_BOOT;
    end
    else
    begin
      unique case (state_q)
        MBC_ST_BOOT:
          state_q <= jumper_load_i ? MBC_ST_FWLOAD : MBC_ST_RUN;
        MBC_ST_RUN:
          if (restart_q)
          begin
            state_q <= MBC_ST_BOOT;
          end
        MBC_ST_FWLOAD:
          state_q <= MBC_ST_FWLOAD;
        default:
          state_q <= MBC_ST_BOOT;
      endcase
    end
  end

  // Live parameters change in boot; in run only a watchdog period write changes one.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      slave_addr_o         <= `MBC_DEF_SLAVE;
      baud_code_o          <= `MBC_DEF_BAUD;
      parity_o             <= `MBC_DEF_PARITY;
      data_bits_o          <= `MBC_DEF_BITS;
      stop_bits_o          <= `MBC_DEF_STOP;
      frame_mode_o         <= `MBC_DEF_MODE;
      link_silence_timer_o <= `MBC_DEF_WDT;
      reply_delay_o        <= `MBC_DEF_DELAY;
    end
    else if (state_q == MBC_ST_BOOT)
    begin
      if (jumper_load_i)
      begin
        baud_code_o <= `MBC_LOAD_BAUD;
        data_bits_o <= `MBC_LOAD_BITS;
        parity_o    <= `MBC_LOAD_PARITY;
        stop_bits_o <= `MBC_LOAD_STOP;
      end
      else if (jumper_init_i)
      begin
        slave_addr_o         <= `MBC_DEF_SLAVE;
        baud_code_o          <= `MBC_DEF_BAUD;
        parity_o             <= `MBC_DEF_PARITY;
        data_bits_o          <= `MBC_DEF_BITS;
        stop_bits_o          <= `MBC_DEF_STOP;
        frame_mode_o         <= `MBC_DEF_MODE;
        link_silence_timer_o <= `MBC_DEF_WDT;
        reply_delay_o        <= `MBC_DEF_DELAY;
      end
      else
      begin
        slave_addr_o         <= nvm_slave_i;
        baud_code_o          <= nvm_baud_i;
        parity_o             <= nvm_parity_i;
        data_bits_o          <= nvm_bits_i;
        stop_bits_o          <= nvm_stop_i;
        frame_mode_o         <= nvm_mode_i;
        link_silence_timer_o <= nvm_wdt_i;
        reply_delay_o        <= nvm_delay_i;
      end
    end
    else if (take && req_func_i == `MBC_FN_WR_REG
             && req_addr_i == `MBC_OFS_WDT)
    begin
      // The watchdog period is the one parameter that acts at once.
      link_silence_timer_o <= req_data_i;
    end
  end

  always_comb
  begin
    exc_d     = 1'b0;
    code_d    = 8'h00;
    data_d    = 16'h0000;
    fwd_d     = 1'b0;
    nvm_d     = 1'b0;
    restart_d = 1'b0;
    unique case (req_func_i)
      `MBC_FN_RD_HOLD:
        if (!reg_exists(req_addr_i))
        begin
          exc_d  = 1'b1;
          code_d = `MBC_EXC_ADDR;
        end
        else
        begin
          unique case (req_addr_i)
            `MBC_OFS_SLAVE:  data_d = slave_addr_o;
            `MBC_OFS_BAUD:   data_d = baud_code_o;
            `MBC_OFS_PARITY: data_d = parity_o;
            `MBC_OFS_BITS:   data_d = data_bits_o;
            `MBC_OFS_STOP:   data_d = stop_bits_o;
            `MBC_OFS_MODE:   data_d = frame_mode_o;
            `MBC_OFS_WDT:    data_d = link_silence_timer_o;
            `MBC_OFS_DELAY:  data_d = reply_delay_o;
            `MBC_OFS_FW_REV: data_d = FW_REV;
            default:         data_d = 16'h0000;
          endcase
        end
      `MBC_FN_WR_REG:
        if (!reg_exists(req_addr_i))
        begin
          exc_d  = 1'b1;
          code_d = `MBC_EXC_ADDR;
        end
        else
        begin
          // The revision register simply ignores the write.
          data_d    = req_data_i;
          nvm_d     = is_param(req_addr_i);
          restart_d = req_addr_i == `MBC_OFS_REBOOT
                      && req_data_i == `MBC_REBOOT_KEY;
        end
      `MBC_FN_EXC_STAT:
        data_d = `MBC_EXC_STATUS;
      `MBC_FN_DIAG:
        if (req_addr_i == `MBC_SUB_ECHO
            || req_addr_i == `MBC_SUB_RESTART)
        begin
          data_d    = req_data_i;
          restart_d = req_addr_i == `MBC_SUB_RESTART;
        end
        else
        begin
          exc_d  = 1'b1;
          code_d = `MBC_EXC_FUNC;
        end
      default:
        if (is_supported(req_func_i))
        begin
          fwd_d = 1'b1;
        end
        else
        begin
          exc_d  = 1'b1;
          code_d = `MBC_EXC_FUNC;
        end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      reply_valid_o <= 1'b0;
      reply_func_o  <= 8'h00;
      reply_exc_o   <= 1'b0;
      reply_code_o  <= 8'h00;
      reply_data_o  <= 16'h0000;
      reply_fwd_o   <= 1'b0;
    end
    else
    begin
      reply_valid_o <= take;
      reply_fwd_o   <= take && fwd_d;
      if (take)
      begin
        reply_func_o <= exc_d ? (req_func_i | `MBC_FN_EXC_FLAG) : req_func_i;
        reply_exc_o  <= exc_d;
        reply_code_o <= code_d;
        reply_data_o <= data_d;
      end
    end
  end

  // Saved parameters reach the store; only the watchdog period also reaches its live register.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      nvm_we_o    <= 1'b0;
      nvm_addr_o  <= 16'h0000;
      nvm_wdata_o <= 16'h0000;
    end
    else
    begin
      nvm_we_o <= take && nvm_d;
      if (take && nvm_d)
      begin
        nvm_addr_o  <= req_addr_i;
        nvm_wdata_o <= req_data_i;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i || state_q == MBC_ST_BOOT)
    begin
      restart_q <= 1'b0;
    end
    else if (take && restart_d)
    begin
      restart_q <= 1'b1;
    end
  end

  // Every command taken restarts the silence count; zero disables it.
  always_ff @(posedge clock_i)
  begin
    if (srst_i || take || link_silence_timer_o == 16'h0000)
    begin
      tick_q    <= 32'h0000_0000;
      secs_q    <= 16'h0000;
      expired_q <= 1'b0;
      failsafe_o <= 1'b0;
    end
    else if (expired_q)
    begin
      failsafe_o <= 1'b0;
    end
    else if (secs_q == link_silence_timer_o)
    begin
      expired_q  <= 1'b1;
      failsafe_o <= 1'b1;
    end
    else if (tick_q == WDT_TICK - 32'h0000_0001)
    begin
      tick_q <= 32'h0000_0000;
      secs_q <= secs_q + 16'h0001;
    end
    else
    begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  mbc_blink
  #(
    .HALF_CYCLES (BLINK_CYCLES)
  )
  u_blink
  (
    .clock_i  (clock_i),
    .srst_i   (srst_i),
    .enable_i (state_q == MBC_ST_FWLOAD),
    .led_o    (led_o)
  );

  default clocking cb @(posedge clock_i);
  endclocking

  default disable iff (srst_i);

  sequence s_restart_req;
    take && req_func_i == `MBC_FN_DIAG && req_addr_i == `MBC_SUB_RESTART;
  endsequence

  sequence s_reply_then_boot;
    reply_valid_o ##1 (state_q == MBC_ST_BOOT) ##1 run_o;
  endsequence

  chk_fw_rev_read: assert property (
    take && req_func_i == `MBC_FN_RD_HOLD && req_addr_i == `MBC_OFS_FW_REV
    |=> reply_valid_o && reply_data_o == FW_REV && !reply_exc_o)
    else $error("Firmware revision read returned a wrong value.");

  chk_default_load: assert property (
    state_q == MBC_ST_BOOT && jumper_init_i && !jumper_load_i
    |=> slave_addr_o == `MBC_DEF_SLAVE && baud_code_o == `MBC_DEF_BAUD
        && frame_mode_o == `MBC_DEF_MODE && link_silence_timer_o == 16'h0000)
    else $error("Factory defaults were not loaded at boot.");

  chk_nvm_copy_in: assert property (
    state_q == MBC_ST_BOOT && !jumper_init_i && !jumper_load_i
    |=> slave_addr_o == $past(nvm_slave_i) && run_o
        && reply_delay_o == $past(nvm_delay_i))
    else $error("Stored parameters were not copied in at boot.");

  chk_param_defer: assert property (
    take && req_func_i == `MBC_FN_WR_REG && req_addr_i == `MBC_OFS_BAUD
    |=> nvm_we_o && $stable(baud_code_o) ##1 $stable(baud_code_o))
    else $error("Parameter write changed a live setting.");

  chk_restart_seq: assert property (
    s_restart_req |=> s_reply_then_boot)
    else $error("Diagnostics restart did not return to boot.");

  chk_exc_status: assert property (
    take && req_func_i == `MBC_FN_EXC_STAT
    |=> reply_func_o == `MBC_FN_EXC_STAT && reply_data_o == 16'h0000
        && !reply_exc_o)
    else $error("Exception status reply was not zero.");

  chk_bad_function: assert property (
    take && !is_supported(req_func_i)
    |=> reply_exc_o && reply_code_o == `MBC_EXC_FUNC
        && reply_func_o[7])
    else $error("Unsupported function was not refused.");

  chk_served_codes: assert property (
    take && is_supported(req_func_i) && req_func_i != `MBC_FN_DIAG
    |=> !(reply_exc_o && reply_code_o == `MBC_EXC_FUNC))
    else $error("Supported function was refused.");

  chk_load_line: assert property (
    fw_load_o |-> baud_code_o == `MBC_LOAD_BAUD
                  && data_bits_o == `MBC_LOAD_BITS && !run_o)
    else $error("Load mode line settings are wrong.");

  chk_wdt_off: assert property (
    link_silence_timer_o == 16'h0000 |=> !failsafe_o)
    else $error("Fail-safe fired with the watchdog disabled.");

endmodule

// >>> bench/mbc_master.sv
// Behavioural bus master that hands single requests to the block.
// Assumes the block samples a request on the rising clock edge.
`timescale 1ns/1ns

module mbc_master
(
  input  wire logic        clock_i,
  output logic             req_valid_o,
  output logic [7:0]       req_func_o,
  output logic [15:0]      req_addr_o,
  output logic [15:0]      req_data_o
);
  initial
  begin
    req_valid_o = 1'b0;
    req_func_o  = 8'h00;
    req_addr_o  = 16'h0000;
    req_data_o  = 16'h0000;
  end

  // Released fields are inverted so a late sample cannot match by luck.
  task automatic send(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d);
    @(posedge clock_i);
    #1;
    req_valid_o = 1'b1;
    req_func_o  = f;
    req_addr_o  = a;
    req_data_o  = d;
    @(posedge clock_i);
    #1;
    req_valid_o = 1'b0;
    req_func_o  = ~f;
    req_addr_o  = ~a;
    req_data_o  = ~d;
  endtask
endmodule

// >>> bench/mbc_dispatch_bench.sv
// Self-checking bench of the configuration and dispatch block.
// Assumes the block's own assertions sit inside its design files.
`timescale 1ns/1ns
`include "mbc_regs.svh"

module mbc_dispatch_bench;
  import mbc_pkg::*;

  // Arbitrary revision value.
  localparam logic [15:0] REV = 16'h0203;
  localparam logic [15:0] DEFS [8] = '{`MBC_DEF_SLAVE, `MBC_DEF_BAUD,
    `MBC_DEF_PARITY, `MBC_DEF_BITS, `MBC_DEF_STOP, `MBC_DEF_MODE,
    `MBC_DEF_WDT, `MBC_DEF_DELAY};
  localparam logic [7:0] CODES [11] = '{8'h01, 8'h03, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h0F, 8'h10, 8'h11, 8'h16, 8'h17};

  typedef struct
  {
    logic [7:0]  func;
    logic        exc;
    logic [7:0]  code;
    logic [15:0] data;
    logic        fwd;
    logic        skip;
  } mbc_note_s;

  logic        clock_i       = 1'b0;
  logic        srst_i        = 1'b1;
  logic        jumper_init_i = 1'b0;
  logic        jumper_load_i = 1'b0;
  logic [15:0] nvm_q [8]     = '{default: 16'h0000};
  logic [15:0] live [8];
  logic        req_valid;
  logic [7:0]  req_func;
  logic [15:0] req_addr;
  logic [15:0] req_data;
  logic        reply_valid_o;
  logic        reply_exc_o;
  logic        reply_fwd_o;
  logic        nvm_we_o;
  logic        run_o;
  logic        fw_load_o;
  logic        failsafe_o;
  logic        led_o;
  logic [7:0]  reply_func_o;
  logic [7:0]  reply_code_o;
  logic [15:0] reply_data_o;
  logic [15:0] nvm_addr_o;
  logic [15:0] nvm_wdata_o;
  int          failures      = 0;
  int          n_compared    = 0;
  int          cycles        = 0;
  int          seed          = 32'h331f_6cdd;
  mbc_note_s   notes [$];
  mbc_note_s   n;

  always #4 clock_i = ~clock_i;

  mbc_master master_u
  (
    .clock_i     (clock_i),
    .req_valid_o (req_valid),
    .req_func_o  (req_func),
    .req_addr_o  (req_addr),
    .req_data_o  (req_data)
  );

  mbc_dispatch #(.FW_REV(REV), .WDT_TICK(10), .BLINK_CYCLES(4)) dut_u
  (
    .clock_i(clock_i), .srst_i(srst_i), .jumper_init_i(jumper_init_i),
    .jumper_load_i(jumper_load_i), .nvm_slave_i(nvm_q[0]),
    .nvm_baud_i(nvm_q[1]), .nvm_parity_i(nvm_q[2]), .nvm_bits_i(nvm_q[3]),
    .nvm_stop_i(nvm_q[4]), .nvm_mode_i(nvm_q[5]), .nvm_wdt_i(nvm_q[6]),
    .nvm_delay_i(nvm_q[7]), .req_valid_i(req_valid),
    .req_func_i(req_func), .req_addr_i(req_addr), .req_data_i(req_data),
    .reply_valid_o(reply_valid_o), .reply_func_o(reply_func_o),
    .reply_exc_o(reply_exc_o), .reply_code_o(reply_code_o),
    .reply_data_o(reply_data_o), .reply_fwd_o(reply_fwd_o),
    .nvm_we_o(nvm_we_o), .nvm_addr_o(nvm_addr_o),
    .nvm_wdata_o(nvm_wdata_o), .slave_addr_o(live[0]),
    .baud_code_o(live[1]), .parity_o(live[2]), .data_bits_o(live[3]),
    .stop_bits_o(live[4]), .frame_mode_o(live[5]),
    .link_silence_timer_o(live[6]), .reply_delay_o(live[7]),
    .run_o(run_o), .fw_load_o(fw_load_o), .failsafe_o(failsafe_o),
    .led_o(led_o)
  );

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clock_i);
    #1;
  endtask

  task automatic req(input logic [7:0] f, input logic [15:0] a, d,
                     input logic e, input logic [7:0] c,
                     input logic [15:0] x, input logic fw, sk);
    notes.push_back('{f, e, c, x, fw, sk});
    master_u.send(f, a, d);
  endtask

  // Jumpers and stored values change here in the same step that raises reset, before the next edge.
  task automatic boot(input logic init, input logic load);
    step();
    for (int i = 0; i < 8; i++)
      nvm_q[i] = 16'($random(seed));
    jumper_init_i = init;
    jumper_load_i = load;
    srst_i = 1'b1;
    repeat (2) step();
    srst_i = 1'b0;
    repeat (2) step();
  endtask

  task automatic live_chk(input logic [15:0] exp [8]);
    for (int i = 0; i < 8; i++)
      chk(live[i], exp[i], "live setting");
  endtask

  always @(negedge clock_i)
    if (reply_valid_o === 1'b1 || reply_fwd_o === 1'b1)
    begin
      if (notes.size() == 0)
        chk(16'h0001, 16'h0000, "unexpected reply");
      else
      begin
        n = notes.pop_front();
        if (n.fwd)
          chk(16'(reply_fwd_o), 16'h0001, "forward");
        else
        begin
          chk(16'(reply_valid_o), 16'h0001, "reply");
          chk(16'(reply_exc_o), 16'(n.exc), "exc flag");
          chk(16'(reply_func_o), 16'({n.exc, 7'h00} | n.func), "func");
          if (n.exc)
            chk(16'(reply_code_o), 16'(n.code), "code");
          else if (!n.skip)
            chk(reply_data_o, n.data, "data");
        end
      end
    end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      chk(16'h0001, 16'h0000, "timeout");
      stop_test();
    end
  end

  initial
  begin : main
    logic [15:0] d;
    logic [7:0]  f;
    logic        prev;
    int          k;
    boot(1'b1, 1'b0);
    chk(16'(run_o), 16'h0001, "run after init");
    live_chk(DEFS);
    $display("test defaults done");
    boot(1'b0, 1'b0);
    chk(16'(run_o), 16'h0001, "run after boot");
    live_chk(nvm_q);
    req(`MBC_FN_RD_HOLD, `MBC_OFS_FW_REV, 16'h0000, 0, 0, REV, 0, 0);
    req(`MBC_FN_WR_REG, `MBC_OFS_FW_REV, 16'h1234, 0, 0, 0, 0, 1);
    req(`MBC_FN_RD_HOLD, `MBC_OFS_FW_REV, 16'h0000, 0, 0, REV, 0, 0);
    d = 16'($random(seed));
    req(`MBC_FN_WR_REG, `MBC_OFS_BAUD, d, 0, 0, d, 0, 0);
    chk(16'(nvm_we_o), 16'h0001, "store strobe");
    chk(nvm_addr_o, `MBC_OFS_BAUD, "store addr");
    chk(nvm_wdata_o, d, "store data");
    chk(live[1], nvm_q[1], "baud deferred");
    $display("test revision and store done");
    foreach (CODES[i])
    begin
      f = CODES[i];
      req(f, (f == 8'h03) ? 16'h0009 : (f == 8'h06) ? 16'h0001 : 16'h0000,
          d, 0, 0, (f == 8'h03) ? REV : (f == 8'h07) ? `MBC_EXC_STATUS : d,
          f inside {8'h01, 8'h05, 8'h0F, 8'h10, 8'h11, 8'h16, 8'h17}, 0);
    end
    req(8'h02, 16'h0000, d, 1, `MBC_EXC_FUNC, 0, 0, 0);
    req(8'h2B, 16'h0000, d, 1, `MBC_EXC_FUNC, 0, 0, 0);
    req(`MBC_FN_RD_HOLD, 16'h0040, d, 1, `MBC_EXC_ADDR, 0, 0, 0);
    req(`MBC_FN_DIAG, 16'h0005, d, 1, `MBC_EXC_FUNC, 0, 0, 0);
    $display("test function codes done");
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < 8; i++)
        nvm_q[i] = 16'($random(seed));
      if (r == 0)
        req(`MBC_FN_DIAG, `MBC_SUB_RESTART, 0, 0, 0, 0, 0, 0);
      else
        req(`MBC_FN_WR_REG, `MBC_OFS_REBOOT, `MBC_REBOOT_KEY, 0, 0,
            `MBC_REBOOT_KEY, 0, 0);
      step();
      chk(16'(run_o), 16'h0000, "restart boot");
      step();
      chk(16'(run_o), 16'h0001, "restart run");
      live_chk(nvm_q);
    end
    $display("test restarts done");
    req(`MBC_FN_WR_REG, `MBC_OFS_WDT, 16'h0002, 0, 0, 16'h0002, 0, 0);
    step();
    chk(live[6], 16'h0002, "watchdog live");
    k = 0;
    while (failsafe_o !== 1'b1 && k < 60)
    begin
      step();
      k++;
    end
    chk(16'(failsafe_o), 16'h0001, "watchdog expiry");
    req(`MBC_FN_WR_REG, `MBC_OFS_WDT, 16'h0000, 0, 0, 16'h0000, 0, 0);
    k = 0;
    repeat (60)
    begin
      step();
      k += int'(failsafe_o === 1'b1);
    end
    chk(16'(k), 16'h0000, "watchdog off");
    $display("test watchdog done");
    boot(1'b1, 1'b1);
    chk(16'(fw_load_o), 16'h0001, "load mode");
    chk(16'(run_o), 16'h0000, "no run in load");
    live_chk('{`MBC_DEF_SLAVE, `MBC_LOAD_BAUD, `MBC_LOAD_PARITY,
      `MBC_LOAD_BITS, `MBC_LOAD_STOP, `MBC_DEF_MODE, `MBC_DEF_WDT,
      `MBC_DEF_DELAY});
    master_u.send(`MBC_FN_RD_HOLD, `MBC_OFS_FW_REV, 16'h0000);
    k = 0;
    prev = led_o;
    repeat (40)
    begin
      step();
      k += int'(led_o !== prev);
      prev = led_o;
    end
    chk(16'(k), 16'h000A, "led toggles");
    boot(1'b0, 1'b0);
    chk(16'(run_o), 16'h0001, "back to run");
    chk(16'(led_o), 16'h0000, "led idle");
    chk(16'(notes.size()), 16'h0000, "replies missing");
    $display("test load mode done");
    stop_test();
  end
endmodule
